// file: rtl/gdcr_defs.vh
// Behaviour
// RL1: Pan delay field bits 0-2 delays horizontal sync by 1 to 7 dots.
// RL2: Software steps pan to 7, then clears it and advances start address.
// RL3: Bits 3-5 of pan/zoom control select the horizontal zoom factor.
// RL4: Bits 6-7 select vertical zoom, setting scan lines per pixel.
// RL5: Software loads zoom factors of one for a normal display.
// RL6: Light-pen register bits 0-2 return the low three X coordinate bits.
// RL7: Light-pen register bits 3-5 return the low three Y coordinate bits.
// RL8: Upper pen bits are five latch bits at 256, six at 512; unused zero.
// RL9: Each plane video enable bit passes its plane when one, blocks when zero.
// RL10: Plane video enables sit at 08H/09H on the data port's bit positions.
// RL11: Location 0EH moves data to and from the selected timing chip register.
// RL12: Vector write with bit 0 set increments X.
// RL13: Vector write with bit 1 set increments Y.
// RL14: Vector write with bit 2 set decrements X.
// RL15: Vector write with bit 3 set decrements Y.
// RL16: Vector write with bit 4 clear stores data register to memory.
// RL17: Software does not use vector stepping in DMA mode.
// RL18: Zoom cells are 8x8 pixels, or 16x8 in double resolution.
// RL19: Cell field is 32x32, 64x32 or 64x64 by model.
// RL20: Vertical zoom 2-8 in 512-wide formats, only 2-4 at 256x256. Code gives 1-4 lines per pixel in all formats.
// RL21: Software sizes zoom window by cell counts divided by zoom, rounded down.
// RL22: Software writes window corner to start registers, then zoom factors.
// RL23: Control bit 4 sets DMA mode; coordinates increment before each byte. Code takes DMA mode from dma_mode_i and steps X only.
// RL24: Pan delay of zero adds no delay to horizontal sync.
`ifndef GDCR_DEFS_VH
`define GDCR_DEFS_VH
`define GDCR_OFF_VEN_LO   4'h8
`define GDCR_OFF_VEN_HI   4'h9
`define GDCR_OFF_WEN_LO   4'hA
`define GDCR_OFF_WEN_HI   4'hB
`define GDCR_OFF_PANZOOM  4'hC
`define GDCR_OFF_PEN      4'hD
`define GDCR_OFF_TCDATA   4'hE
`define GDCR_OFF_VECTOR   4'hF
`define GDCR_PAN_LSB      0
`define GDCR_PAN_MSB      2
`define GDCR_HZ_LSB       3
`define GDCR_HZ_MSB       5
`define GDCR_VZ_LSB       6
`define GDCR_VZ_MSB       7
`define GDCR_VEC_XUP      0
`define GDCR_VEC_YUP      1
`define GDCR_VEC_XDN      2
`define GDCR_VEC_YDN      3
`define GDCR_VEC_NOSTORE  4
`define GDCR_RST_BYTE     8'h00
`define GDCR_PEN_LOW_W    3
`define GDCR_CELL_H       3'h7
`define GDCR_CELL_W_DBL   4'hF
`define GDCR_LINE_MAX     5'h1F
`endif

// file: rtl/gdcr_sync_delay.v
`timescale 1ns/1ns
// Horizontal sync delayed by a programmable number of dots
module gdcr_sync_delay #(
	parameter DEPTH = 7,
	parameter SEL_W = 3
) (
	// Clock and reset
	input  wire             clk_i,
	input  wire             rst_b_i,
	input  wire             dot_en_i,
	// Sync path
	input  wire [SEL_W-1:0] sel_i,
	input  wire             sync_i,
	output reg              sync_o
);
	reg  [DEPTH-1:0] taps;
	integer        k;

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			taps <= {DEPTH{1'b0}};
		end else if (dot_en_i) begin
			taps[0] <= sync_i;
			for (k = 1; k < DEPTH; k = k + 1) begin
				taps[k] <= taps[k-1];
			end
		end
	end

	// Zero selects the undelayed tap
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			sync_o <= 1'b0;
		end else if (sel_i == {SEL_W{1'b0}}) begin
			sync_o <= sync_i; // RL24
		end else begin
			sync_o <= taps[sel_i - 1'b1]; // RL1
		end
	end
endmodule

// file: rtl/gdcr_regs.v
`timescale 1ns/1ns
`include "gdcr_defs.vh"
module gdcr_regs #(
	parameter COORD_W = 10,
	parameter NPLANE  = 4,
	parameter LATCH_W = 6
) (
	// Clock and reset
	input  wire               clk_i,
	input  wire               rst_b_i,
	// Host I/O port
	input  wire [3:0]         io_addr_i,
	input  wire               io_wr_i,
	input  wire               io_rd_i,
	input  wire [7:0]         io_wdata_i,
	output reg  [7:0]         io_rdata_o,
	// Board configuration
	input  wire               fmt512_i,
	input  wire               dma_mode_i,
	input  wire               dbl_res_i,
	// Coordinate load from address registers
	input  wire               x_load_i,
	input  wire               y_load_i,
	input  wire [COORD_W-1:0] coord_i,
	input  wire               dma_step_i,
	// Coordinates and store request
	output reg  [COORD_W-1:0] x_coord_o,
	output reg  [COORD_W-1:0] y_coord_o,
	output reg                mem_store_o,
	// Timing chip data port
	output reg                tc_wr_o,
	output reg                tc_rd_o,
	output reg  [7:0]         tc_wdata_o,
	input  wire [7:0]         tc_rdata_i,
	// Light pen
	input  wire               pen_hit_i,
	input  wire [LATCH_W-1:0] pen_col_latch_i,
	input  wire [LATCH_W-1:0] pen_row_latch_i,
	output reg  [LATCH_W-1:0] pen_col_upper_o,
	output reg  [LATCH_W-1:0] pen_row_upper_o,
	// Video path
	input  wire               hsync_i,
	input  wire               cell_row_start_i,
	input  wire [NPLANE-1:0]  plane_video_i,
	output reg  [NPLANE-1:0]  plane_video_o,
	output reg                hsync_o,
	output reg                dot_en_o,
	output reg                line_adv_o,
	output reg  [2:0]         pan_delay_o,
	output reg  [2:0]         horiz_expand_o,
	output reg  [1:0]         vert_expand_o,
	output reg  [5:0]         cell_col_o
);
	reg  [7:0]         plane_video_enable_low;
	reg  [7:0]         plane_video_enable_high;
	reg  [7:0]         plane_write_enable_low;
	reg  [7:0]         plane_write_enable_high;
	reg  [7:0]         pan_zoom_control;
	reg  [2:0]         pen_x_low_bits;
	reg  [2:0]         pen_y_low_bits;
	reg  [2:0]         dot_cnt;
	reg  [3:0]         dot_in_cell;
	reg  [4:0]         line_cnt;
	reg  [2:0]         pen_x_run;
	reg  [2:0]         pen_y_run;
	reg                hsync_q;
	reg  [NPLANE-1:0]  plane_video_on;
	reg  [7:0]         next_rdata;
	reg  [COORD_W-1:0] next_x;
	reg  [COORD_W-1:0] next_y;
	reg  [4:0]         lines_per_pixel;
	reg  [3:0]         cell_w_m1;
	wire               vec_wr;
	wire               hsync_rise;
	wire               sync_dly;
	wire [2:0]         pan_delay_field;
	wire [2:0]         horiz_expand_field;
	wire               vert_expand_bit_lo;
	wire               vert_expand_bit_hi;
	wire               step_x_up;
	wire               step_y_up;
	wire               step_x_down;
	wire               step_y_down;
	wire               suppress_auto_store;
	wire [LATCH_W-1:0] latch_mask;

	assign pan_delay_field     = pan_zoom_control[`GDCR_PAN_MSB:`GDCR_PAN_LSB];
	assign horiz_expand_field  = pan_zoom_control[`GDCR_HZ_MSB:`GDCR_HZ_LSB];
	assign vert_expand_bit_lo  = pan_zoom_control[`GDCR_VZ_LSB];
	assign vert_expand_bit_hi  = pan_zoom_control[`GDCR_VZ_MSB];
	assign vec_wr              = io_wr_i && (io_addr_i == `GDCR_OFF_VECTOR);
	assign step_x_up           = io_wdata_i[`GDCR_VEC_XUP];
	assign step_y_up           = io_wdata_i[`GDCR_VEC_YUP];
	assign step_x_down         = io_wdata_i[`GDCR_VEC_XDN];
	assign step_y_down         = io_wdata_i[`GDCR_VEC_YDN];
	assign suppress_auto_store = io_wdata_i[`GDCR_VEC_NOSTORE];
	// Five latch bits at 256 formats, six at 512
	assign latch_mask = fmt512_i ? {LATCH_W{1'b1}} : {1'b0, {(LATCH_W-1){1'b1}}}; // RL8
	// Line sync is a level: count lines on its rising edge only
	assign hsync_rise = hsync_i & ~hsync_q;

	// Host writable registers
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			plane_video_enable_low  <= `GDCR_RST_BYTE;
			plane_video_enable_high <= `GDCR_RST_BYTE;
			plane_write_enable_low  <= `GDCR_RST_BYTE;
			plane_write_enable_high <= `GDCR_RST_BYTE;
			pan_zoom_control        <= `GDCR_RST_BYTE;
		end else if (io_wr_i) begin
			case (io_addr_i)
			`GDCR_OFF_VEN_LO: begin
				plane_video_enable_low <= io_wdata_i; // RL10
			end
			`GDCR_OFF_VEN_HI: begin
				plane_video_enable_high <= io_wdata_i; // RL10
			end
			`GDCR_OFF_WEN_LO: begin
				plane_write_enable_low <= io_wdata_i;
			end
			`GDCR_OFF_WEN_HI: begin
				plane_write_enable_high <= io_wdata_i;
			end
			`GDCR_OFF_PANZOOM: begin
				pan_zoom_control <= io_wdata_i;
			end
			default: begin
			end
			endcase
		end
	end

	// Enables follow the data port nibble of each location
	always @* begin
		plane_video_on = plane_video_enable_low[NPLANE-1:0] | plane_video_enable_high[NPLANE-1:0]; // RL10
	end

	genvar p;
	generate
		for (p = 0; p < NPLANE; p = p + 1) begin : g_plane
			always @(posedge clk_i) begin
				if (!rst_b_i) begin
					plane_video_o[p] <= 1'b0;
				end else begin
					plane_video_o[p] <= plane_video_i[p] & plane_video_on[p]; // RL9
				end
			end
		end
	endgenerate

	// Dot clock: board clock divided by the X zoom factor
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			dot_cnt  <= 3'h0;
			dot_en_o <= 1'b0;
		end else if (dot_cnt >= horiz_expand_field) begin
			dot_cnt  <= 3'h0;
			dot_en_o <= 1'b1; // RL3
		end else begin
			dot_cnt  <= dot_cnt + 3'h1;
			dot_en_o <= 1'b0;
		end
	end

	// Cell width and scan lines per pixel
	always @* begin
		cell_w_m1       = dbl_res_i ? `GDCR_CELL_W_DBL : {1'b0, `GDCR_CELL_H}; // RL18
		lines_per_pixel = {3'h0, vert_expand_bit_hi, vert_expand_bit_lo} + 5'h1;
		if (!fmt512_i && lines_per_pixel > 5'h4) begin
			lines_per_pixel = 5'h4; // RL20
		end
	end

	// Cell column counter, double resolution cells are twice as wide
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			dot_in_cell <= 4'h0;
			cell_col_o  <= 6'h00;
		end else if (hsync_i) begin
			dot_in_cell <= 4'h0;
			cell_col_o  <= 6'h00;
		end else if (dot_en_o) begin
			if (dot_in_cell == cell_w_m1) begin
				dot_in_cell <= 4'h0;
				cell_col_o  <= cell_col_o + 6'h01; // RL19
			end else begin
				dot_in_cell <= dot_in_cell + 4'h1; // RL18
			end
		end
	end

	// Line sync rising edge
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			hsync_q <= 1'b0;
		end else begin
			hsync_q <= hsync_i;
		end
	end

	// Line repeat: each pixel held for the vertical zoom count
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			line_cnt   <= 5'h0;
			line_adv_o <= 1'b0;
		end else if (cell_row_start_i) begin
			line_cnt   <= 5'h0;
			line_adv_o <= 1'b0;
		end else if (hsync_rise) begin
			if (line_cnt + 5'h1 >= lines_per_pixel) begin
				line_cnt   <= 5'h0;
				line_adv_o <= 1'b1; // RL4
			end else begin
				line_cnt   <= line_cnt + 5'h1;
				line_adv_o <= 1'b0;
			end
		end else begin
			line_adv_o <= 1'b0;
		end
	end

	gdcr_sync_delay #(
		.DEPTH (7),
		.SEL_W (3)
	) u_sync_delay (
		.clk_i    (clk_i),
		.rst_b_i  (rst_b_i),
		.dot_en_i (dot_en_o),
		.sel_i    (pan_delay_field),
		.sync_i   (hsync_i),
		.sync_o   (sync_dly)
	);

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			hsync_o        <= 1'b0;
			pan_delay_o    <= 3'h0;
			horiz_expand_o <= 3'h0;
			vert_expand_o  <= 2'h0;
		end else begin
			hsync_o        <= sync_dly; // RL1
			pan_delay_o    <= pan_delay_field;
			horiz_expand_o <= horiz_expand_field; // RL3
			vert_expand_o  <= {vert_expand_bit_hi, vert_expand_bit_lo}; // RL4
		end
	end

	// Light pen fine position within the cell
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pen_x_run      <= 3'h0;
			pen_y_run      <= 3'h0;
			pen_x_low_bits <= 3'h0;
			pen_y_low_bits <= 3'h0;
		end else begin
			if (hsync_i) begin
				pen_x_run <= 3'h0;
			end else if (dot_en_o) begin
				pen_x_run <= pen_x_run + 3'h1;
			end
			if (cell_row_start_i) begin
				pen_y_run <= 3'h0;
			end else if (hsync_rise) begin
				pen_y_run <= pen_y_run + 3'h1;
			end
			if (pen_hit_i) begin
				pen_x_low_bits <= pen_x_run; // RL6
				pen_y_low_bits <= pen_y_run; // RL7
			end
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pen_col_upper_o <= {LATCH_W{1'b0}};
			pen_row_upper_o <= {LATCH_W{1'b0}};
		end else begin
			pen_col_upper_o <= pen_col_latch_i & latch_mask; // RL8
			pen_row_upper_o <= pen_row_latch_i & latch_mask; // RL8
		end
	end

	// Coordinate pointer stepping
	always @* begin
		next_x = x_coord_o;
		next_y = y_coord_o;
		if (x_load_i) begin
			next_x = coord_i;
		end
		if (y_load_i) begin
			next_y = coord_i;
		end
		if (dma_mode_i && dma_step_i) begin
			next_x = x_coord_o + {{(COORD_W-1){1'b0}}, 1'b1}; // RL23
		end else if (vec_wr && !dma_mode_i) begin
			if (step_x_up) begin
				next_x = next_x + {{(COORD_W-1){1'b0}}, 1'b1}; // RL12
			end
			if (step_x_down) begin
				next_x = next_x - {{(COORD_W-1){1'b0}}, 1'b1}; // RL14
			end
			if (step_y_up) begin
				next_y = next_y + {{(COORD_W-1){1'b0}}, 1'b1}; // RL13
			end
			if (step_y_down) begin
				next_y = next_y - {{(COORD_W-1){1'b0}}, 1'b1}; // RL15
			end
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			x_coord_o   <= {COORD_W{1'b0}};
			y_coord_o   <= {COORD_W{1'b0}};
			mem_store_o <= 1'b0;
		end else begin
			x_coord_o   <= next_x;
			y_coord_o   <= next_y;
			mem_store_o <= vec_wr && !suppress_auto_store; // RL16
		end
	end

	// Timing chip data port strobes
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			tc_wr_o    <= 1'b0;
			tc_rd_o    <= 1'b0;
			tc_wdata_o <= 8'h00;
		end else begin
			tc_wr_o <= io_wr_i && (io_addr_i == `GDCR_OFF_TCDATA); // RL11
			tc_rd_o <= io_rd_i && (io_addr_i == `GDCR_OFF_TCDATA); // RL11
			if (io_wr_i && (io_addr_i == `GDCR_OFF_TCDATA)) begin
				tc_wdata_o <= io_wdata_i;
			end
		end
	end

	// Read mux
	always @* begin
		case (io_addr_i)
		`GDCR_OFF_VEN_LO:  next_rdata = plane_video_enable_low;
		`GDCR_OFF_VEN_HI:  next_rdata = plane_video_enable_high;
		`GDCR_OFF_WEN_LO:  next_rdata = plane_write_enable_low;
		`GDCR_OFF_WEN_HI:  next_rdata = plane_write_enable_high;
		`GDCR_OFF_PANZOOM: next_rdata = pan_zoom_control;
		`GDCR_OFF_PEN:     next_rdata = {2'h0, pen_y_low_bits, pen_x_low_bits}; // RL6
		`GDCR_OFF_TCDATA:  next_rdata = tc_rdata_i; // RL11
		default:           next_rdata = 8'h00;
		endcase
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			io_rdata_o <= 8'h00;
		end else if (io_rd_i) begin
			io_rdata_o <= next_rdata;
		end
	end
endmodule

// file: testbench/gdcr_regs_chk.sv
`timescale 1ns/1ns
module gdcr_regs_chk #(
	parameter COORD_W = 10
) (
	// Clock and reset
	input wire               clk_i,
	input wire               rst_b_i,
	// Host port and configuration
	input wire [3:0]         io_addr_i,
	input wire               io_wr_i,
	input wire               io_rd_i,
	input wire [7:0]         io_wdata_i,
	input wire [7:0]         io_rdata_o,
	input wire               dma_mode_i,
	input wire               x_load_i,
	input wire               y_load_i,
	input wire               dma_step_i,
	// Observed outputs
	input wire [COORD_W-1:0] x_coord_o,
	input wire [COORD_W-1:0] y_coord_o,
	input wire               mem_store_o,
	input wire               tc_wr_o,
	input wire               tc_rd_o,
	input wire [7:0]         tc_wdata_o,
	input wire [2:0]         pan_delay_o,
	input wire [2:0]         horiz_expand_o,
	input wire [1:0]         vert_expand_o
);
	// Vector write with no competing pointer update
	wire vw = io_wr_i && io_addr_i == 4'hF && !dma_mode_i && !x_load_i && !y_load_i && !dma_step_i;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	sequence pz_wr; io_wr_i && io_addr_i == 4'hC; endsequence
	sequence pz_rd; io_rd_i && io_addr_i == 4'hC; endsequence
	x_up_a: assert property (
		vw && io_wdata_i[0] && !io_wdata_i[2] |=> x_coord_o == $past(x_coord_o) + 1'b1) else $error("x step up wrong");
	y_up_a: assert property (
		vw && io_wdata_i[1] && !io_wdata_i[3] |=> y_coord_o == $past(y_coord_o) + 1'b1) else $error("y step up wrong");
	x_down_a: assert property (
		vw && io_wdata_i[2] && !io_wdata_i[0] |=> x_coord_o == $past(x_coord_o) - 1'b1) else $error("x step down wrong");
	y_down_a: assert property (
		vw && io_wdata_i[3] && !io_wdata_i[1] |=> y_coord_o == $past(y_coord_o) - 1'b1) else $error("y step down wrong");
	auto_store_a: assert property (
		vw |=> mem_store_o == !$past(io_wdata_i[4])) else $error("auto store wrong");
	tc_write_a: assert property (
		io_wr_i && io_addr_i == 4'hE |=> tc_wr_o && tc_wdata_o == $past(io_wdata_i)) else $error("timing chip write wrong");
	pz_fields_a: assert property (
		pz_wr |=> ##1 {vert_expand_o, horiz_expand_o, pan_delay_o} == $past(io_wdata_i, 2))
		else $error("pan zoom fields wrong");
	tc_read_a: assert property (
		io_rd_i && io_addr_i == 4'hE |=> tc_rd_o) else $error("timing chip read wrong");
	pz_readback_a: assert property (
		pz_wr ##2 pz_rd |=> ##1 io_rdata_o == $past(io_wdata_i, 4)) else $error("pan zoom readback wrong");
	unmapped_rd_a: assert property (
		io_rd_i && !io_addr_i[3] ##1 !io_rd_i |=> io_rdata_o == 8'h00) else $error("unmapped read not zero");
endmodule
bind gdcr_regs gdcr_regs_chk #(.COORD_W(COORD_W)) u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr_i),
	.io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .dma_mode_i(dma_mode_i),
	.x_load_i(x_load_i), .y_load_i(y_load_i), .dma_step_i(dma_step_i), .x_coord_o(x_coord_o), .y_coord_o(y_coord_o),
	.mem_store_o(mem_store_o), .tc_wr_o(tc_wr_o), .tc_rd_o(tc_rd_o), .tc_wdata_o(tc_wdata_o), .pan_delay_o(pan_delay_o),
	.horiz_expand_o(horiz_expand_o), .vert_expand_o(vert_expand_o));

// file: testbench/gdcr_tc_model.sv
`timescale 1ns/1ns
// Timing chip data port: the selected register
module gdcr_tc_model (
	input  wire       clk_i,
	input  wire       tc_wr_i,
	input  wire [7:0] tc_wdata_i,
	output wire [7:0] tc_rdata_o
);
	reg [7:0] sel_reg = 8'h00;
	always @(posedge clk_i) begin
		if (tc_wr_i)
			sel_reg <= tc_wdata_i;
	end
	assign tc_rdata_o = sel_reg;
endmodule

// file: testbench/gdcr_regs_tb.sv
`timescale 1ns/1ns
module gdcr_regs_tb;
	reg        clk_i = 1'b0;
	reg        rst_b_i = 1'b0;
	reg  [3:0] io_addr_i = 4'h0;
	reg        io_wr_i = 1'b0;
	reg        io_rd_i = 1'b0;
	reg  [7:0] io_wdata_i = 8'h00;
	reg        fmt512_i = 1'b0;
	reg        dma_mode_i = 1'b0;
	reg        dbl_res_i = 1'b0;
	reg        x_load_i = 1'b0;
	reg        y_load_i = 1'b0;
	reg  [9:0] coord_i = 10'h000;
	reg        dma_step_i = 1'b0;
	reg        pen_hit_i = 1'b0;
	reg  [5:0] pen_col_latch_i = 6'h3F;
	reg  [5:0] pen_row_latch_i = 6'h2A;
	reg        hsync_i = 1'b0;
	reg        cell_row_start_i = 1'b0;
	reg  [3:0] plane_video_i = 4'hF;
	wire [7:0] io_rdata_o, tc_wdata_o, tc_rdata_i;
	wire [9:0] x_coord_o, y_coord_o;
	wire [5:0] pen_col_upper_o, pen_row_upper_o, cell_col_o;
	wire [3:0] plane_video_o;
	wire [2:0] pan_delay_o, horiz_expand_o;
	wire [1:0] vert_expand_o;
	wire       mem_store_o, tc_wr_o, tc_rd_o, hsync_o, dot_en_o, line_adv_o;
	integer    n_fail = 0;
	integer    n_checks = 0;
	integer    i;
	integer    n_lag;
	reg  [9:0] ex, ey;
	reg  [7:0] c, d;
	localparam [55:0] VECS = 56'h01_02_04_08_10_05_0A;

	gdcr_regs u_gdcr_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .io_addr_i(io_addr_i), .io_wr_i(io_wr_i),
		.io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .io_rdata_o(io_rdata_o), .fmt512_i(fmt512_i),
		.dma_mode_i(dma_mode_i), .dbl_res_i(dbl_res_i), .x_load_i(x_load_i), .y_load_i(y_load_i),
		.coord_i(coord_i), .dma_step_i(dma_step_i), .x_coord_o(x_coord_o), .y_coord_o(y_coord_o),
		.mem_store_o(mem_store_o), .tc_wr_o(tc_wr_o), .tc_rd_o(tc_rd_o), .tc_wdata_o(tc_wdata_o),
		.tc_rdata_i(tc_rdata_i), .pen_hit_i(pen_hit_i), .pen_col_latch_i(pen_col_latch_i),
		.pen_row_latch_i(pen_row_latch_i), .pen_col_upper_o(pen_col_upper_o), .pen_row_upper_o(pen_row_upper_o),
		.hsync_i(hsync_i), .cell_row_start_i(cell_row_start_i), .plane_video_i(plane_video_i),
		.plane_video_o(plane_video_o), .hsync_o(hsync_o), .dot_en_o(dot_en_o), .line_adv_o(line_adv_o),
		.pan_delay_o(pan_delay_o), .horiz_expand_o(horiz_expand_o), .vert_expand_o(vert_expand_o),
		.cell_col_o(cell_col_o));
	gdcr_tc_model u_gdcr_tc_model (.clk_i(clk_i), .tc_wr_i(tc_wr_o), .tc_wdata_i(tc_wdata_o), .tc_rdata_o(tc_rdata_i));

	task end_of_test;
		begin
			if (n_fail == 0 && n_checks > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask
	task chk(input string nm, input [9:0] e, input [9:0] g);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("unexpected %0s: expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task wr(input [3:0] a, input [7:0] v);
		begin
			@(negedge clk_i) io_addr_i = a;
			io_wdata_i = v;
			io_wr_i = 1'b1;
			@(negedge clk_i) io_wr_i = 1'b0;
		end
	endtask
	task rd(input [3:0] a, output [7:0] v);
		begin
			@(negedge clk_i) io_addr_i = a;
			io_rd_i = 1'b1;
			@(negedge clk_i) io_rd_i = 1'b0;
			@(negedge clk_i) v = io_rdata_o;
		end
	endtask
	task pen_pulse;
		begin
			@(negedge clk_i) pen_hit_i = 1'b1;
			@(negedge clk_i) pen_hit_i = 1'b0;
			@(negedge clk_i);
		end
	endtask
	// Clocks from a line sync rise to the delayed sync rise
	task sync_lag(output integer n);
		begin
			@(posedge hsync_i);
			n = 0;
			while (hsync_o !== 1'b1 && n < 20) begin
				@(negedge clk_i);
				n = n + 1;
			end
		end
	endtask
	// Clocks between two dot enable pulses
	task dot_period(output integer n);
		begin
			n = 0;
			while (dot_en_o !== 1'b1 && n < 20) begin
				@(negedge clk_i);
				n = n + 1;
			end
			@(negedge clk_i);
			n = 1;
			while (dot_en_o !== 1'b1 && n < 20) begin
				@(negedge clk_i);
				n = n + 1;
			end
		end
	endtask
	// Line sync rises between two line advance pulses
	task line_gap(output integer n);
		begin
			n = 0;
			while (line_adv_o !== 1'b1 && n < 10) begin
				@(posedge hsync_i);
				@(negedge clk_i);
				n = n + 1;
			end
			@(posedge hsync_i);
			@(negedge clk_i);
			n = 1;
			while (line_adv_o !== 1'b1 && n < 10) begin
				@(posedge hsync_i);
				@(negedge clk_i);
				n = n + 1;
			end
		end
	endtask

	initial begin
		forever #5 clk_i = ~clk_i;
	end
	// Line sync toggles so the delay path sees traffic
	initial begin
		forever begin
			repeat (37) @(negedge clk_i);
			hsync_i = ~hsync_i;
		end
	end
	initial begin
		repeat (6000) @(posedge clk_i);
		n_fail = n_fail + 1;
		end_of_test;
	end

	initial begin
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		rd(4'hC, d); chk("pan zoom reset", 10'h000, {2'b00, d});
		wr(4'h5, 8'hFF);
		rd(4'h5, d); chk("unmapped", 10'h000, {2'b00, d});
		wr(4'hC, 8'h77);
		rd(4'hC, d); chk("pan zoom", 10'h077, {2'b00, d});
		chk("pan", 10'h007, {7'h00, pan_delay_o});
		chk("h zoom", 10'h006, {7'h00, horiz_expand_o});
		chk("v zoom", 10'h001, {8'h00, vert_expand_o});
		wr(4'hC, 8'h00);
		@(negedge clk_i); chk("pan zero", 10'h000, {7'h00, pan_delay_o});
		for (i = 0; i < 8; i = i + 1) begin
			wr(4'hC, i[7:0]);
			sync_lag(n_lag);
			chk("sync lag", i[9:0] + 10'h002, n_lag[9:0]);
		end
		wr(4'hC, 8'h18);
		dot_period(n_lag);
		chk("dot period", 10'h004, n_lag[9:0]);
		wr(4'hC, 8'hC0);
		line_gap(n_lag);
		chk("line gap", 10'h004, n_lag[9:0]);
		for (i = 0; i < 2; i = i + 1) begin
			dbl_res_i = i[0];
			@(negedge hsync_i);
			repeat (9) @(negedge clk_i);
			pen_pulse;
			repeat (8) @(negedge clk_i);
			chk("cell col", 10'h002 >> i, {4'h0, cell_col_o});
			rd(4'hD, d); chk("pen x low", 10'h002, {7'h00, d[2:0]});
		end
		wr(4'hC, 8'h00);
		wr(4'h8, 8'h05);
		@(negedge clk_i); chk("video low", 10'h005, {6'h00, plane_video_o});
		wr(4'h9, 8'h08);
		@(negedge clk_i); chk("video both", 10'h00D, {6'h00, plane_video_o});
		rd(4'h9, d); chk("video high", 10'h008, {2'b00, d});
		wr(4'hE, 8'h3C);
		@(negedge clk_i); chk("tc model", 10'h03C, {2'b00, u_gdcr_tc_model.sel_reg});
		rd(4'hE, d); chk("tc read", 10'h03C, {2'b00, d});
		@(negedge clk_i) x_load_i = 1'b1;
		y_load_i = 1'b1;
		coord_i = 10'h200;
		@(negedge clk_i) x_load_i = 1'b0;
		y_load_i = 1'b0;
		ex = 10'h200;
		ey = 10'h200;
		for (i = 6; i >= 0; i = i - 1) begin
			c = VECS[8*i +: 8];
			wr(4'hF, c);
			ex = ex + {9'h000, c[0]} - {9'h000, c[2]};
			ey = ey + {9'h000, c[1]} - {9'h000, c[3]};
			chk("x", ex, x_coord_o);
			chk("y", ey, y_coord_o);
			chk("store", {9'h000, !c[4]}, {9'h000, mem_store_o});
		end
		@(negedge clk_i) dma_mode_i = 1'b1;
		wr(4'hF, 8'h01); chk("x in dma", ex, x_coord_o);
		@(negedge clk_i) dma_step_i = 1'b1;
		@(negedge clk_i) dma_step_i = 1'b0;
		chk("dma step", ex + 10'h001, x_coord_o);
		dma_mode_i = 1'b0;
		pen_pulse;
		chk("pen col 256", 10'h01F, {4'h0, pen_col_upper_o});
		chk("pen row 256", 10'h00A, {4'h0, pen_row_upper_o});
		fmt512_i = 1'b1;
		pen_pulse;
		chk("pen col 512", 10'h03F, {4'h0, pen_col_upper_o});
		chk("pen row 512", 10'h02A, {4'h0, pen_row_upper_o});
		rd(4'hD, d); chk("pen low top", 10'h000, {8'h00, d[7:6]});
		end_of_test;
	end
endmodule
